// *** msa_aggregate.sv ***
// Weighted multi-sensor aggregate rate engine with AHB-Lite registers
`timescale 1ns/1ns
module msa_aggregate (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Measurement channels
   input msa_pkg::msa_meas_t meas,
   input wire logic backup_running,
   // Layer sequencing
   input msa_pkg::msa_phase_t phase_a,
   input msa_pkg::msa_phase_t phase_b,
   input wire logic layer_done,
   // Results
   output logic [23:0] agg_rate,
   output logic agg_valid,
   output logic [31:0] multiplier,
   output msa_pkg::msa_act_t action,
   output logic sensor_conflict,
   output logic [7:0] owner_b
);
   import msa_pkg::*;

   // ==========================================================
   // State
   typedef enum logic [2:0] {S_IDLE, S_ACC, S_DIV_LIVE, S_DIV_PRE, S_DIV_MULT, S_OUT} msa_fsm_t;

   typedef struct packed {
      logic aw_en;
      logic aw_wr;
      logic [7:0] aw_addr;
      logic [31:0] rdata;
      logic ready;
      logic multi;
      logic comp_en;
      logic [2:0] sel;
      logic [13:0] mtool;
      logic [7:0] mask_a;
      logic [7:0] mask_b;
      msa_scfg_t [7:0] scfg;
      logic [7:0][23:0] avg;
      logic [7:0][15:0] rate;
      logic [7:0] fail;
      logic [7:0] seen;
      logic [7:0] newfail;
      msa_fsm_t fsm;
      logic [2:0] idx;
      logic [39:0] live_wr;
      logic [39:0] pre_wr;
      logic [14:0] live_w;
      logic [14:0] pre_w;
      logic [47:0] div_num;
      logic [47:0] div_den;
      logic [47:0] div_rem;
      logic [5:0] div_cnt;
      logic [23:0] live_agg;
      logic [23:0] pre_agg;
      logic [31:0] mult;
      logic mult_valid;
      logic [23:0] agg;
      logic agg_valid;
      msa_act_t act;
      logic conflict;
      logic [7:0] owner_b;
   } msa_st_t;

   // ==========================================================
   // Functions
   // Reset image of the whole state
   function automatic msa_st_t rst_state();
      msa_st_t s;
      s = '0;
      s.ready = 1'b1;
      s.mtool = TOOL_RST;
      s.mult = MULT_ONE;
      s.fsm = S_IDLE;
      for (int i = 0; i < NSENS; i++)
      begin
         s.scfg[i].trigger = TRIGGER_LAST;
         s.scfg[i].action = (i == 0) ? ACT_STOP : ACT_UNUSED;
         s.scfg[i].tooling = TOOL_RST;
         s.scfg[i].weight = WT_RST;
      end
      return s;
   endfunction

   localparam msa_st_t ST_RST = rst_state();

   // Sensor configuration page hit
   function automatic logic cfg_hit(input logic [7:0] a);
      return a[7:5] == OFF_CFG_PAGE;
   endfunction

   // Sensor weight page hit
   function automatic logic wt_hit(input logic [7:0] a);
      return a[7:5] == OFF_WT_PAGE;
   endfunction

   // Displayed rate, Q8.8 in, Q16.8 out, toolings in tenths of a percent
   function automatic logic [23:0] disp_rate(input logic [15:0] r, input logic [13:0] mt,
                                             input logic [13:0] st);
      logic [43:0] p;
      p = 44'(r) * 44'(mt) * 44'(st);
      return 24'(p / TOOL_SQ);
   endfunction

   // Register read mux
   function automatic logic [31:0] rd_mux(input msa_st_t s, input logic [7:0] a);
      logic [31:0] v;
      v = '0;
      if (cfg_hit(a))
         v = {2'h0, s.scfg[a[4:2]].tooling, 11'h0, s.scfg[a[4:2]].trigger, 1'b0,
              s.scfg[a[4:2]].action};
      else if (wt_hit(a))
         v = (s.scfg[a[4:2]].action == ACT_UNUSED) ? 32'h0 : {20'h0, s.scfg[a[4:2]].weight};
      else
         case (a)
            OFF_CTRL: v = {25'h0, s.sel, 2'h0, s.comp_en, s.multi};
            OFF_STATUS: v = {25'h0, s.act, (s.fsm != S_IDLE), s.mult_valid, s.conflict};
            OFF_AGG: v = {8'h0, s.agg};
            OFF_MULT: v = s.mult;
            OFF_MTOOL: v = {18'h0, s.mtool};
            OFF_LMASK: v = {16'h0, s.mask_b, s.mask_a};
            OFF_OWNER: v = {24'h0, s.owner_b};
            default: v = '0;
         endcase
      return v;
   endfunction

   msa_st_t q;
   msa_st_t d;

   // ==========================================================
   // Next state
   always_comb
   begin
      logic [7:0] used;
      logic [23:0] dr;
      logic [11:0] w;
      logic [47:0] rem_sh;
      logic ge;
      logic [47:0] quot;
      logic [7:0] added;
      logic both_started;
      logic [55:0] scaled;
      logic [2:0] i;
      used = '0;
      dr = '0;
      w = '0;
      rem_sh = '0;
      ge = 1'b0;
      quot = '0;
      added = '0;
      scaled = '0;
      i = q.idx;
      both_started = (phase_a != PH_IDLE) && (phase_b != PH_IDLE);
      d = q;
      d.agg_valid = 1'b0;
      d.ready = 1'b1;

      // Sensors taking part in the aggregate
      for (int k = 0; k < NSENS; k++)
         used[k] = q.multi ? (q.scfg[k].action != ACT_UNUSED)
                           : (q.sel == 3'(k));

      // Layer end clears per-layer flags before new events set them
      if (layer_done)
      begin
         d.seen = '0;
         d.act = '0;
      end

      // Register write in data phase
      if (q.aw_en && q.aw_wr)
      begin
         if (cfg_hit(q.aw_addr))
         begin
            if (!backup_running && hwdata[2:0] <= ACT_TIME_POWER_FINISH)
            begin
               d.scfg[q.aw_addr[4:2]].action = hwdata[2:0];
               d.scfg[q.aw_addr[4:2]].trigger = hwdata[CFG_TRIG_BIT];
            end
            if (hwdata[CFG_TOOL_LSB+:14] >= TOOL_MIN && hwdata[CFG_TOOL_LSB+:14] <= TOOL_MAX)
               d.scfg[q.aw_addr[4:2]].tooling = hwdata[CFG_TOOL_LSB+:14];
         end
         else if (wt_hit(q.aw_addr))
         begin
            // Blocked for unused sensors, range checked
            if (q.scfg[q.aw_addr[4:2]].action != ACT_UNUSED &&
                hwdata[11:0] >= WT_MIN && hwdata[11:0] <= WT_MAX)
               d.scfg[q.aw_addr[4:2]].weight = hwdata[11:0];
         end
         else
            case (q.aw_addr)
               OFF_CTRL:
               begin
                  d.multi = hwdata[CTRL_MULTI_BIT];
                  d.comp_en = hwdata[CTRL_COMP_BIT];
                  d.sel = hwdata[CTRL_SEL_LSB+:3];
               end
               OFF_STATUS:
                  if (hwdata[STAT_CONFLICT_BIT])
                     d.conflict = 1'b0;
               OFF_MTOOL:
                  if (hwdata[13:0] >= TOOL_MIN && hwdata[13:0] <= TOOL_MAX)
                     d.mtool = hwdata[13:0];
               OFF_LMASK:
               begin
                  // Refuse enabling a sensor the other layer uses while both layers are started
                  added = hwdata[7:0] & ~q.mask_a;
                  d.mask_a = both_started ? (hwdata[7:0] & ~(added & q.mask_b))
                                          : hwdata[7:0];
                  added = hwdata[15:8] & ~q.mask_b;
                  d.mask_b = both_started ? (hwdata[15:8] & ~(added & d.mask_a))
                                          : hwdata[15:8];
               end
               default: d.conflict = q.conflict;
            endcase
      end

      // Address phase capture and registered read data
      d.aw_en = hsel && htrans[1] && hready;
      d.aw_wr = hwrite;
      d.aw_addr = haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite)
         d.rdata = rd_mux(q, haddr[7:0]);

      // Shared sensor goes to the depositing layer
      d.owner_b = q.mask_b & ~(q.mask_a & {8{phase_a == PH_DEPOSIT && phase_b != PH_DEPOSIT}});
      if (phase_a == PH_DEPOSIT && phase_b == PH_DEPOSIT && |(q.mask_a & q.mask_b))
      begin
         d.conflict = 1'b1;
         d.act.stop_all = 1'b1;
      end

      // Serial restoring divider step, quotient shifts into div_num
      rem_sh = {q.div_rem[46:0], q.div_num[47]};
      ge = rem_sh >= q.div_den;
      if (q.fsm == S_DIV_LIVE || q.fsm == S_DIV_PRE || q.fsm == S_DIV_MULT)
      begin
         d.div_rem = ge ? rem_sh - q.div_den : rem_sh;
         d.div_num = {q.div_num[46:0], ge};
         d.div_cnt = q.div_cnt - 6'h01;
      end
      quot = (q.div_den == 48'h0) ? 48'h0 : d.div_num;

      // Calculation sequence, one pass per measurement set
      unique case (q.fsm)
         S_IDLE:
            if (meas.valid)
            begin
               d.rate = meas.rate;
               d.fail = meas.fail;
               d.newfail = meas.fail & used & ~d.seen;
               d.live_wr = '0;
               d.pre_wr = '0;
               d.live_w = '0;
               d.pre_w = '0;
               d.idx = '0;
               d.fsm = S_ACC;
            end
         S_ACC:
         begin
            // One channel per cycle over all eight
            dr = disp_rate(q.rate[i], q.mtool, q.scfg[i].tooling);
            w = q.multi ? q.scfg[i].weight : WT_SINGLE;
            if (used[i] && !q.fail[i])
            begin
               d.live_wr = q.live_wr + 40'(dr) * 40'(w);
               d.live_w = q.live_w + 15'(w);
               d.avg[i] = (q.avg[i] == 24'h0) ? dr : q.avg[i] - (q.avg[i] >> 3) + (dr >> 3);
            end
            if (used[i] && (!q.fail[i] || q.newfail[i]))
            begin
               d.pre_wr = q.pre_wr + 40'(q.newfail[i] ? q.avg[i] : dr) * 40'(w);
               d.pre_w = q.pre_w + 15'(w);
            end
            d.idx = q.idx + 3'h1;
            if (q.idx == 3'h7)
            begin
               d.div_num = {8'h00, d.live_wr};
               d.div_den = {33'h0, d.live_w};
               d.div_rem = '0;
               d.div_cnt = DIV_STEPS;
               d.fsm = S_DIV_LIVE;
            end
         end
         S_DIV_LIVE:
            if (q.div_cnt == 6'h00)
            begin
               d.live_agg = quot[23:0];
               if (q.multi && q.comp_en && !q.mult_valid && |q.newfail)
               begin
                  d.div_num = {8'h00, q.pre_wr};
                  d.div_den = {33'h0, q.pre_w};
                  d.div_rem = '0;
                  d.div_cnt = DIV_STEPS;
                  d.fsm = S_DIV_PRE;
               end
               else
                  d.fsm = S_OUT;
            end
         S_DIV_PRE:
            if (q.div_cnt == 6'h00)
            begin
               d.pre_agg = quot[23:0];
               d.div_num = {8'h00, quot[23:0], 16'h0000};
               d.div_den = {24'h0, q.live_agg};
               d.div_rem = '0;
               d.div_cnt = DIV_STEPS;
               d.fsm = S_DIV_MULT;
            end
         S_DIV_MULT:
            if (q.div_cnt == 6'h00)
            begin
               if (q.div_den != 48'h0)
               begin
                  d.mult = quot[31:0];
                  d.mult_valid = 1'b1;
               end
               d.fsm = S_OUT;
            end
         S_OUT:
         begin
            scaled = 56'(q.live_agg) * 56'(q.mult);
            d.agg = (q.comp_en && q.mult_valid) ? scaled[39:16] : q.live_agg;
            d.agg_valid = 1'b1;
            d.seen = d.seen | q.newfail;
            // Failure actions of freshly failed sensors
            for (int k = 0; k < NSENS; k++)
               if (q.newfail[k] && (q.scfg[k].trigger == TRIGGER_ON_OWN_FAILURE ||
                   (used & ~d.seen) == 8'h00))
                  unique case (q.scfg[k].action)
                     ACT_GO_POST_DEPOSIT: d.act.go_post_deposit = 1'b1;
                     ACT_STOP: d.act.stop_all = 1'b1;
                     ACT_SUSPEND: d.act.suspend_layer = 1'b1;
                     ACT_TIME_POWER_FINISH: d.act.time_power_finish = 1'b1;
                     default: d.act = d.act;
                  endcase
            d.fsm = S_IDLE;
         end
      endcase

      // Layer end returns the multiplier to unity
      if (layer_done)
      begin
         d.mult = MULT_ONE;
         d.mult_valid = 1'b0;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         q <= ST_RST;
      else
         q <= d;
   end

   // Outputs straight from state, hresp held low
   assign hrdata = q.rdata;
   assign hreadyout = q.ready;
   assign hresp = 1'b0;
   assign agg_rate = q.agg;
   assign agg_valid = q.agg_valid;
   assign multiplier = q.mult;
   assign action = q.act;
   assign sensor_conflict = q.conflict;
   assign owner_b = q.owner_b;

   // ==========================================================
   // Checks
   logic [7:0][2:0] act_vec;
   logic [7:0] shared;
   logic wt_ok;
   always_comb
   begin
      wt_ok = 1'b1;
      for (int k = 0; k < NSENS; k++)
      begin
         act_vec[k] = q.scfg[k].action;
         if (q.scfg[k].weight < WT_MIN || q.scfg[k].weight > WT_MAX)
            wt_ok = 1'b0;
      end
      shared = q.mask_a & q.mask_b;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   AST_SINGLE_ONE_SENSOR: assert property (
      (q.fsm == S_DIV_LIVE && $past(q.fsm) == S_ACC && !q.multi) |-> q.live_w <= 15'h0001)
      else $error("single mode summed more than one sensor");
   AST_MULT_NEEDS_ENABLE: assert property ($rose(q.mult_valid) |-> q.comp_en)
      else $error("multiplier computed while compensation disabled");
   AST_LAYER_CLEARS_MULT: assert property (layer_done |=> q.mult == MULT_ONE && !q.mult_valid)
      else $error("multiplier not unity after layer end");
   AST_PLAIN_WHEN_OFF: assert property ((q.agg_valid && !q.comp_en) |-> q.agg == q.live_agg)
      else $error("aggregate scaled while compensation disabled");
   AST_MULT_REUSED: assert property ((q.mult_valid && !layer_done) |=> $stable(q.mult))
      else $error("multiplier recomputed within layer");
   AST_LOCK_ON_BACKUP: assert property (
      (q.aw_en && q.aw_wr && backup_running) |=> act_vec == $past(act_vec))
      else $error("failure action changed while backup running");
   AST_CONFLICT_STOP: assert property (
      (phase_a == PH_DEPOSIT && phase_b == PH_DEPOSIT && shared != 8'h00)
      |=> q.conflict && q.act.stop_all)
      else $error("sensor conflict not flagged");
   AST_NO_NEW_SHARING: assert property (
      (phase_a != PH_IDLE && phase_b != PH_IDLE) |=> (shared & ~$past(shared)) == 8'h00)
      else $error("sensor enabled for both started layers");
   AST_WEIGHT_RANGE: assert property (wt_ok)
      else $error("sensor weight out of range");
   AST_RESULT_LATENCY: assert property (
      (q.fsm == S_IDLE && meas.valid) |-> ##[10:200] q.agg_valid)
      else $error("aggregate result late");

   COV_MULT: cover property ($rose(q.mult_valid));
   COV_SCALED: cover property (q.agg_valid && q.comp_en && q.mult_valid);
   COV_CONFLICT: cover property ($rose(q.conflict));
   COV_ACTION: cover property ($rose(q.act.time_power_finish));

endmodule // msa_aggregate

// *** msa_pkg.sv ***
// Shared constants and types of the multi-sensor aggregate rate block
package msa_pkg;

   // ==========================================================
   // Geometry
   localparam int NSENS = 8;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_AGG = 8'h08;
   localparam logic [7:0] OFF_MULT = 8'h0C;
   localparam logic [7:0] OFF_MTOOL = 8'h10;
   localparam logic [7:0] OFF_LMASK = 8'h14;
   localparam logic [7:0] OFF_OWNER = 8'h18;
   localparam logic [2:0] OFF_CFG_PAGE = 3'h2;
   localparam logic [2:0] OFF_WT_PAGE = 3'h3;

   // ==========================================================
   // Field positions
   localparam int CTRL_MULTI_BIT = 0;
   localparam int CTRL_COMP_BIT = 1;
   localparam int CTRL_SEL_LSB = 4;
   localparam int STAT_CONFLICT_BIT = 0;
   localparam int CFG_TRIG_BIT = 4;
   localparam int CFG_TOOL_LSB = 16;

   // ==========================================================
   // Failure actions and triggers
   localparam logic [2:0] ACT_UNUSED = 3'h0;
   localparam logic [2:0] ACT_GO_POST_DEPOSIT = 3'h1;
   localparam logic [2:0] ACT_STOP = 3'h2;
   localparam logic [2:0] ACT_SUSPEND = 3'h3;
   localparam logic [2:0] ACT_TIME_POWER_FINISH = 3'h4;
   localparam logic TRIGGER_ON_OWN_FAILURE = 1'h0;
   localparam logic TRIGGER_LAST = 1'h1;

   // ==========================================================
   // Ranges and reset values, toolings and weights in tenths of a percent
   localparam logic [13:0] TOOL_RST = 14'h03E8;
   localparam logic [13:0] TOOL_MIN = 14'h000A;
   localparam logic [13:0] TOOL_MAX = 14'h270F;
   localparam logic [11:0] WT_RST = 12'h3E8;
   localparam logic [11:0] WT_MIN = 12'h00A;
   localparam logic [11:0] WT_MAX = 12'hFA0;
   localparam logic [11:0] WT_SINGLE = 12'h001;
   localparam logic [43:0] TOOL_SQ = 44'h000000F4240;
   localparam logic [31:0] MULT_ONE = 32'h0001_0000;
   localparam logic [5:0] DIV_STEPS = 6'h2F;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {PH_IDLE, PH_PRE, PH_DEPOSIT, PH_POST} msa_phase_t;

   typedef struct packed {
      logic trigger;
      logic [2:0] action;
      logic [13:0] tooling;
      logic [11:0] weight;
   } msa_scfg_t;

   typedef struct packed {
      logic valid;
      logic [7:0] fail;
      logic [7:0][15:0] rate;
   } msa_meas_t;

   typedef struct packed {
      logic go_post_deposit;
      logic stop_all;
      logic suspend_layer;
      logic time_power_finish;
   } msa_act_t;

endpackage

// *** msa_sensor_model.sv ***
// Behavioural model of the eight sensor measurement channels
`timescale 1ns/1ns
module msa_sensor_model (
   // Clock
   input wire logic ref_clk,
   // Measurement sets
   output msa_pkg::msa_meas_t meas
);
   import msa_pkg::*;
   // ==========================================================
   // Channels idle at time zero
   initial meas = '0;
   // One set: valid for one cycle, rates scrambled once it drops
   task automatic send(input logic [7:0][15:0] r, input logic [7:0] f);
      meas.rate <= r;
      meas.fail <= f;
      meas.valid <= 1'b1;
      @(posedge ref_clk);
      meas.valid <= 1'b0;
      meas.rate <= ~r; // Stale rates never pass for live ones
   endtask
endmodule // msa_sensor_model

// *** tb_top.sv ***
// Self-checking bench of the aggregate rate block over AHB-Lite
`timescale 1ns/1ns
module tb_top;
   import msa_pkg::*;
   // ==========================================================
   // Bus, channel and layer signals
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   msa_meas_t meas;
   logic backup_running = 1'b0;
   msa_phase_t phase_a = PH_IDLE;
   msa_phase_t phase_b = PH_IDLE;
   logic layer_done = 1'b0;
   logic [23:0] agg_rate;
   logic agg_valid;
   logic [31:0] multiplier;
   msa_act_t action;
   logic sensor_conflict;
   logic [7:0] owner_b;
   logic [31:0] rdv;
   logic [7:0][15:0] tbl = {64'h0, 16'h0400, 16'h0A00, 16'h0A00, 16'h1000};
   int bad_count = 0;
   int checks_done = 0;
   // Free-running 100 MHz clock
   always #5 ref_clk = ~ref_clk;
   // Device under test and channel model
   msa_aggregate u_msa_aggregate (
      .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .meas(meas), .backup_running(backup_running), .phase_a(phase_a),
      .phase_b(phase_b), .layer_done(layer_done), .agg_rate(agg_rate),
      .agg_valid(agg_valid), .multiplier(multiplier), .action(action),
      .sensor_conflict(sensor_conflict), .owner_b(owner_b));
   msa_sensor_model u_msa_sensor_model (.ref_clk(ref_clk), .meas(meas));
   // Compare and count
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Bounded wait for hready or a result pulse
   task automatic wait_on(input logic agg);
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while ((agg ? agg_valid : hreadyout) !== 1'b1 && n < 400);
      if ((agg ? agg_valid : hreadyout) !== 1'b1)
      begin
         bad_count++;
         test_done();
      end
   endtask
   // Single AHB-Lite transfer, read data kept in rdv
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_on(1'b0);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_on(1'b0);
      rdv = hrdata;
   endtask
   // Read and compare
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rdv, e);
   endtask
   // Sensor page and weight of one channel
   task automatic cfg(input int i, input logic [2:0] act, input logic trg,
                      input logic [13:0] tl, input logic [11:0] w);
      bus(1'b1, {OFF_CFG_PAGE, 3'(i), 2'h0}, {2'h0, tl, 11'h0, trg, 1'b0, act});
      bus(1'b1, {OFF_WT_PAGE, 3'(i), 2'h0}, {20'h0, w});
   endtask
   // One measurement set and its result
   task automatic send(input logic [7:0][15:0] r, input logic [7:0] f);
      u_msa_sensor_model.send(r, f);
      wait_on(1'b1);
   endtask
   // End of layer
   task automatic done_pulse();
      layer_done <= 1'b1;
      @(posedge ref_clk);
      layer_done <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   // Main sequence
   initial
   begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < NSENS; i++)
      begin
         rc({OFF_CFG_PAGE, 3'(i), 2'h0}, (i == 0) ? 32'h03E8_0012 : 32'h03E8_0010);
         rc({OFF_WT_PAGE, 3'(i), 2'h0}, (i == 0) ? 32'h0000_03E8 : 32'h0);
      end
      rc(OFF_MULT, MULT_ONE);
      rc(8'hFC, 32'h0);
      send({{7{16'h0300}}, 16'h0500}, 8'h00);
      check({8'h00, agg_rate}, 32'h0500);
      bus(1'b1, OFF_CTRL, 32'h10);
      send({{7{16'h0300}}, 16'h0500}, 8'h00);
      check({8'h00, agg_rate}, 32'h0300);
      // Mixed tooling and weights, displayed rates of sensors 0 to 3 equal
      bus(1'b1, OFF_CTRL, 32'h1);
      bus(1'b1, OFF_MTOOL, 32'h7D0);
      cfg(0, ACT_GO_POST_DEPOSIT, 1'b1, 14'h3E8, 12'h1F4);
      cfg(1, ACT_GO_POST_DEPOSIT, 1'b1, 14'h1F4, 12'h3E8);
      cfg(2, ACT_GO_POST_DEPOSIT, 1'b1, 14'h1F4, 12'h2EE);
      cfg(3, ACT_GO_POST_DEPOSIT, 1'b1, 14'h7D0, 12'h0FA);
      bus(1'b1, {OFF_WT_PAGE, 3'h0, 2'h0}, 32'hFA1);
      rc({OFF_WT_PAGE, 3'h0, 2'h0}, 32'h1F4);
      bus(1'b1, {OFF_WT_PAGE, 3'h5, 2'h0}, 32'h3E8);
      rc({OFF_WT_PAGE, 3'h5, 2'h0}, 32'h0);
      send({{4{16'h0700}}, 16'h0100, 16'h0400, 16'h0400, 16'h0200}, 8'h00);
      check({8'h00, agg_rate}, 32'h0400);
      // Mid-run reset, so running averages restart from the next set
      reset_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rc({OFF_CFG_PAGE, 3'h0, 2'h0}, 32'h03E8_0012);
      rc({OFF_WT_PAGE, 3'h0, 2'h0}, 32'h0000_03E8);
      // Sensor 0 fails mid-layer with compensation on
      bus(1'b1, OFF_MTOOL, 32'h3E8);
      for (int i = 0; i < 4; i++)
         cfg(i, ACT_GO_POST_DEPOSIT, TRIGGER_LAST, 14'h3E8, 12'h3E8);
      bus(1'b1, OFF_LMASK, 32'h0F);
      phase_a <= PH_DEPOSIT;
      bus(1'b1, OFF_CTRL, 32'h3);
      send(tbl, 8'h00);
      check({8'h00, agg_rate}, 32'h0A00);
      send(tbl, 8'h01);
      check({8'h00, agg_rate}, 32'h0A00);
      check(multiplier, 32'h0001_4000);
      check(32'(action), 32'h0);
      bus(1'b1, OFF_CTRL, 32'h1);
      send(tbl, 8'h01);
      check({8'h00, agg_rate}, 32'h0800);
      bus(1'b1, OFF_CTRL, 32'h3);
      send(tbl, 8'h01);
      check({8'h00, agg_rate}, 32'h0A00);
      check(multiplier, 32'h0001_4000);
      done_pulse();
      check(multiplier, MULT_ONE);
      // Every failure action code on an own-failure trigger
      bus(1'b1, OFF_CTRL, 32'h1);
      for (int c = 1; c < 5; c++)
      begin
         cfg(1, 3'(c), TRIGGER_ON_OWN_FAILURE, 14'h3E8, 12'h3E8);
         send(tbl, 8'h02);
         check(32'(action), 32'(4'h8 >> (c - 1)));
         done_pulse();
         check(32'(action), 32'h0);
      end
      // Action and trigger locked while a backup runs, tooling not
      backup_running <= 1'b1;
      bus(1'b1, {OFF_CFG_PAGE, 3'h1, 2'h0}, 32'h0300_0013);
      rc({OFF_CFG_PAGE, 3'h1, 2'h0}, 32'h0300_0004);
      backup_running <= 1'b0;
      // Shared sensor between the two layers
      phase_a <= PH_IDLE;
      bus(1'b1, OFF_LMASK, 32'h0603);
      phase_a <= PH_DEPOSIT;
      phase_b <= PH_PRE;
      repeat (2) @(posedge ref_clk);
      check(32'(owner_b), 32'h04);
      rc(OFF_OWNER, 32'h04);
      phase_b <= PH_DEPOSIT;
      repeat (2) @(posedge ref_clk);
      check(32'(sensor_conflict), 32'h1);
      check(32'(action.stop_all), 32'h1);
      phase_a <= PH_IDLE;
      phase_b <= PH_IDLE;
      bus(1'b1, OFF_STATUS, 32'h1);
      @(posedge ref_clk);
      check(32'(sensor_conflict), 32'h0);
      done_pulse();
      phase_a <= PH_PRE;
      phase_b <= PH_PRE;
      bus(1'b1, OFF_LMASK, 32'h0703);
      rc(OFF_LMASK, 32'h0603);
      check(32'(hresp), 32'h0);
      test_done();
   end
   // Reset held for three cycles from time zero
endmodule // tb_top
